//--- wdt_pkg.sv
package wdt_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
	localparam logic [3:0] ADDR_POST = 4'h4;
	localparam logic [3:0] ADDR_OSC = 4'h5;

	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int BIT_SOFT_ON = 0;
	localparam int BIT_SINK = 1;
	localparam int BIT_WAKE_EN = 2;
	localparam int BIT_ULTRA = 4;
	localparam int BIT_LEVEL = 5;
	localparam int BIT_REG_LP = 7;
	localparam logic [7:0] CTRL_WMASK = 8'h97;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] OSC_RESET = 8'h00;
	localparam int FSEL_LSB = 4;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int BASE_PERIOD_US = 4000;
	localparam int BASE_CYCLES = BASE_PERIOD_US * CLK_MHZ;
	localparam int BASE_W = 19;
	localparam int POST_W = 16;
	localparam int SYNC_W = 3;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [3:0] {
		MODE_OFF = 4'h1,
		MODE_SOFT = 4'h2,
		MODE_RUN_ONLY = 4'h4,
		MODE_ON = 4'h8
	} wdt_mode_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic reg_lowpower;
		logic ultra_lowpower;
		logic wake_enable;
		logic wake_sink;
		logic osc_enable;
	} power_ctl_t;
endpackage

//--- watchdog_sleep_ctrl.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module watchdog_sleep_ctrl
	import wdt_pkg::*;
#(
	// base period in clock cycles; a bench may shorten it so that expiry is reachable
	parameter int BASE_COUNT = BASE_CYCLES
)
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// configuration and core events
	input wire logic [1:0] watchdog_mode_config,
	input wire logic [3:0] postscale_select,
	input wire logic retention_config_bit,
	input wire logic sleep_instr,
	input wire logic clear_watchdog_instr,
	input wire logic in_sleep,
	input wire logic clock_fail,
	// pins
	input wire logic regulator_enable_pin,
	input wire logic wake_comparator_pin,
	// outputs
	output power_ctl_t power_ctl,
	output logic watchdog_reset,
	output logic watchdog_wake,
	output logic irq
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [1:0] sync1_r;
	logic [1:0] sync2_r;
	logic env_s;
	logic cmp_s;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
		end else begin
			sync1_r <= {regulator_enable_pin, wake_comparator_pin};
			sync2_r <= sync1_r;
		end
	end
	assign env_s = sync2_r[1];
	assign cmp_s = sync2_r[0];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg_req_t req;
	logic [7:0] ctrl_r;
	logic [7:0] osc_r;
	logic [2:0] irq_stat_r;
	logic [2:0] irq_mask_r;
	logic [7:0] ctrl_rd;
	logic ultra_ok;
	logic fsel_change;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign ultra_ok = env_s && !retention_config_bit;
	assign fsel_change = req.wr && req.addr == ADDR_OSC
		&& req.wdata[FSEL_LSB +: 3] != osc_r[FSEL_LSB +: 3];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= CTRL_RESET;
		end else if (req.wr && req.addr == ADDR_CTRL) begin
			ctrl_r <= req.wdata & CTRL_WMASK;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_r <= OSC_RESET;
		end else if (req.wr && req.addr == ADDR_OSC) begin
			osc_r <= req.wdata;
		end
	end

	always_comb begin
		ctrl_rd = ctrl_r;
		ctrl_rd[BIT_LEVEL] = ctrl_r[BIT_WAKE_EN] & cmp_s;
		ctrl_rd[BIT_ULTRA] = ctrl_r[BIT_ULTRA] & ultra_ok;
	end

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	wdt_mode_t mode;
	logic wdt_run;

	always_comb begin
		case (watchdog_mode_config)
			2'h0: mode = MODE_OFF;
			2'h1: mode = MODE_SOFT;
			2'h2: mode = MODE_RUN_ONLY;
			default: mode = MODE_ON;
		endcase
	end

	always_comb begin
		case (mode)
			MODE_ON: wdt_run = 1'b1;
			MODE_RUN_ONLY: wdt_run = !in_sleep;
			MODE_SOFT: wdt_run = ctrl_r[BIT_SOFT_ON];
			MODE_OFF: wdt_run = 1'b0;
			default: wdt_run = 1'b0;
		endcase
	end

	// ----------------------------------------
	// counters
	// ----------------------------------------
	logic [BASE_W-1:0] base_r;
	logic [POST_W-1:0] post_r;
	logic base_tick;
	logic clr;
	logic expire;

	assign clr = sleep_instr || clear_watchdog_instr || fsel_change || clock_fail;
	assign base_tick = wdt_run && base_r == BASE_W'(BASE_COUNT - 1);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			base_r <= '0;
		end else if (clr || base_tick) begin
			base_r <= '0;
		end else if (wdt_run) begin
			base_r <= base_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			post_r <= '0;
		end else if (clr || expire) begin
			post_r <= '0;
		end else if (base_tick) begin
			post_r <= post_r + 1'b1;
		end
	end

	// tap n ends after 2^n base periods
	assign expire = base_tick && post_r == POST_W'((32'h1 << postscale_select) - 32'h1);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			watchdog_reset <= 1'b0;
			watchdog_wake <= 1'b0;
		end else begin
			watchdog_reset <= expire && !in_sleep;
			watchdog_wake <= expire && in_sleep;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	logic [2:0] ev;

	assign ev = {clock_fail, expire && in_sleep, expire && !in_sleep};

	// set wins over write-one-clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_r <= 3'h0;
			irq_mask_r <= 3'h0;
		end else begin
			if (req.wr && req.addr == ADDR_IRQ_STAT) begin
				irq_stat_r <= (irq_stat_r & ~req.wdata[2:0]) | ev;
			end else begin
				irq_stat_r <= irq_stat_r | ev;
			end
			if (req.wr && req.addr == ADDR_IRQ_MASK) begin
				irq_mask_r <= req.wdata[2:0];
			end
		end
	end
	assign irq = |(irq_stat_r & irq_mask_r);

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				ADDR_CTRL: reg_rdata <= ctrl_rd;
				ADDR_STATUS: reg_rdata <= {5'h00, ultra_ok, wdt_run, in_sleep};
				ADDR_IRQ_STAT: reg_rdata <= {5'h00, irq_stat_r};
				ADDR_IRQ_MASK: reg_rdata <= {5'h00, irq_mask_r};
				ADDR_POST: reg_rdata <= post_r[15:8];
				ADDR_OSC: reg_rdata <= osc_r;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// power outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			power_ctl <= '0;
		end else begin
			power_ctl.ultra_lowpower <= in_sleep && ctrl_r[BIT_ULTRA] && ultra_ok;
			power_ctl.reg_lowpower <= in_sleep && ctrl_r[BIT_REG_LP]
				&& !(ctrl_r[BIT_ULTRA] && ultra_ok);
			power_ctl.wake_enable <= ctrl_r[BIT_WAKE_EN];
			power_ctl.wake_sink <= ctrl_r[BIT_WAKE_EN] && ctrl_r[BIT_SINK];
			power_ctl.osc_enable <= wdt_run;
		end
	end
endmodule

//--- wdt_chk_sva.sv
`timescale 1ns/100ps
module wdt_chk
	import wdt_pkg::*;
(
	// clock, reset, register port
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// core side
	input wire logic [1:0] watchdog_mode_config,
	input wire logic in_sleep,
	input wire logic clear_watchdog_instr,
	input wire logic clock_fail,
	input wire power_ctl_t power_ctl,
	input wire logic watchdog_reset,
	input wire logic watchdog_wake,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_reset_one_cycle: assert property (watchdog_reset |=> !watchdog_reset)
		else $error("reset pulse too long");
	a_wake_one_cycle: assert property (watchdog_wake |=> !watchdog_wake)
		else $error("wake pulse too long");
	a_reset_when_awake: assert property (watchdog_reset |-> !$past(in_sleep))
		else $error("reset while asleep");
	a_wake_when_asleep: assert property (watchdog_wake |-> $past(in_sleep))
		else $error("wake while awake");
	a_clear_quiet: assert property (clear_watchdog_instr |-> ##2 (!watchdog_reset)[*8])
		else $error("timeout right after clear");
	a_osc_forced_on: assert property ((watchdog_mode_config == 2'h3)[*2] |-> power_ctl.osc_enable)
		else $error("oscillator off while watchdog on");
	a_ctrl_holes_zero: assert property (reg_rd && reg_addr == ADDR_CTRL |=> reg_rdata[6] == 1'b0 && reg_rdata[3] == 1'b0)
		else $error("unimplemented control bit reads one");
	a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_OSC |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read");
	c_fail: cover property (clock_fail);
	c_irq: cover property ($rose(irq));
	c_clear: cover property (clear_watchdog_instr);
	c_timeout: cover property (watchdog_reset);
	c_wake: cover property (watchdog_wake);
endmodule

bind watchdog_sleep_ctrl wdt_chk chk (.clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata,
	.watchdog_mode_config, .in_sleep, .clear_watchdog_instr, .clock_fail, .power_ctl,
	.watchdog_reset, .watchdog_wake, .irq);

//--- testbench.sv
`timescale 1ns/100ps
module testbench
	import wdt_pkg::*;
;
	logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, ret = 0, slp_i = 0, clr_i = 0;
	logic in_sleep = 0, cfail = 0, pin = 0, cmp = 0, rst_o, wake_o, irq, run;
	logic [3:0] reg_addr = 0, sel = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	logic [1:0] mode = 0;
	power_ctl_t pc;
	int failures = 0, comparisons = 0, cycles = 0;
	// base count shortened so that every timeout fits in the run
	localparam int BASE = 40;
	logic [2:0] fsel = 0;
	watchdog_sleep_ctrl #(.BASE_COUNT(BASE)) uut (.clk, .arst_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd,
		.reg_rdata, .watchdog_mode_config(mode), .postscale_select(sel),
		.retention_config_bit(ret), .sleep_instr(slp_i), .clear_watchdog_instr(clr_i),
		.in_sleep, .clock_fail(cfail), .regulator_enable_pin(pin),
		.wake_comparator_pin(cmp), .power_ctl(pc), .watchdog_reset(rst_o),
		.watchdog_wake(wake_o), .irq);
	always #5 clk = ~clk;
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task check(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		#1 check(reg_rdata, e);
	endtask
	task pulse_gap;
		repeat (4) @(posedge clk);
	endtask
	// how: 0 clear instruction, 1 sleep instruction, 2 frequency change, 3 clock failure
	task expiry(input int how, input logic [1:0] m, input logic s, input logic [3:0] t,
		input logic [7:0] e);
		fsel = fsel + 3'h1;
		@(posedge clk);
		mode <= m;
		in_sleep <= s;
		sel <= t;
		// let the counters run part way so a missing clear shifts the expiry
		repeat (BASE / 2) @(posedge clk);
		clr_i <= how == 0;
		slp_i <= how == 1;
		reg_wr <= how == 2;
		cfail <= how == 3;
		reg_addr <= ADDR_OSC;
		reg_wdata <= {1'b0, fsel, 4'h0};
		@(posedge clk);
		clr_i <= 0;
		slp_i <= 0;
		reg_wr <= 0;
		cfail <= 0;
		repeat ((BASE << t) - 1) @(posedge clk);
		#1 check({6'h00, wake_o, rst_o}, 8'h00);
		@(posedge clk);
		#1 check({6'h00, wake_o, rst_o}, e);
	endtask
	task power(input logic [7:0] c, input logic s, input logic r, input logic [7:0] e);
		@(posedge clk);
		mode <= 2'h0;
		in_sleep <= s;
		ret <= r;
		wr(ADDR_CTRL, c);
		@(posedge clk);
		#1 check({3'h0, pc}, e);
	endtask
	task results;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// timeout guard, far above the five hundred or so cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1;
		rd(ADDR_CTRL, CTRL_RESET);
		rd(4'hF, 8'h00);
		pin <= 1;
		cmp <= 1;
		pulse_gap();
		wr(ADDR_CTRL, 8'hFF);
		rd(ADDR_CTRL, 8'hB7);
		// bit 5 shows the comparator only while the wake module is on
		wr(ADDR_CTRL, 8'h7B);
		rd(ADDR_CTRL, 8'h13);
		pin <= 0;
		pulse_gap();
		rd(ADDR_CTRL, 8'h03);
		pin <= 1;
		ret <= 1;
		pulse_gap();
		rd(ADDR_CTRL, 8'h03);
		$display("test control register done");
		for (int i = 0; i < 16; i++) begin
			mode <= i[3:2];
			in_sleep <= i[0];
			wr(ADDR_CTRL, {7'h00, i[1]});
			run = (i[3:2] == 2'h3) || (i[3:2] == 2'h2 && !i[0]) || (i[3:2] == 2'h1 && i[1]);
			rd(ADDR_STATUS, {6'h00, run, i[0]});
			check({7'h00, pc.osc_enable}, {7'h00, run});
		end
		$display("test modes done");
		expiry(0, 2'h3, 1'b0, 4'h0, 8'h01);
		expiry(1, 2'h3, 1'b1, 4'h1, 8'h02);
		expiry(2, 2'h3, 1'b0, 4'h0, 8'h01);
		rd(ADDR_OSC, {1'b0, fsel, 4'h0});
		expiry(3, 2'h3, 1'b0, 4'h0, 8'h01);
		expiry(1, 2'h2, 1'b1, 4'h0, 8'h00);
		rd(ADDR_IRQ_STAT, 8'h07);
		$display("test timeout done");
		power(8'h80, 1'b1, 1'b0, 8'h10);
		power(8'h90, 1'b1, 1'b0, 8'h08);
		power(8'h90, 1'b1, 1'b1, 8'h10);
		power(8'h80, 1'b0, 1'b0, 8'h00);
		power(8'h02, 1'b0, 1'b0, 8'h00);
		power(8'h06, 1'b0, 1'b0, 8'h06);
		$display("test power control done");
		wr(ADDR_IRQ_MASK, 8'h00);
		wr(ADDR_IRQ_STAT, 8'h07);
		cfail <= 1;
		@(posedge clk);
		cfail <= 0;
		rd(ADDR_IRQ_STAT, 8'h04);
		check({7'h00, irq}, 8'h00);
		wr(ADDR_IRQ_MASK, 8'h04);
		@(posedge clk);
		#1 check({7'h00, irq}, 8'h01);
		wr(ADDR_IRQ_STAT, 8'h04);
		@(posedge clk);
		#1 check({7'h00, irq}, 8'h00);
		rd(ADDR_IRQ_STAT, 8'h00);
		$display("test interrupt done");
		results();
	end
endmodule
